// *** test/host_model.sv ***
// Register bus master that stands in for the processor core.
`timescale 1ns/10ps
module host_model (
  input  wire logic        ref_clk,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // A write is one strobe cycle beside address and data.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the flash protection and boot control block.
`timescale 1ns/10ps
module tb
  import flash_protection_pkg::*;
;
  logic        ref_clk;
  logic        rst;
  logic        factory_init;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        mem_rd;
  logic [15:0] mem_addr;
  logic        mem_dbg;
  logic        mem_fw;
  logic [7:0]  mem_rdata;
  logic        mem_rvalid;
  logic        mem_denied;
  logic        boot_pin;
  logic        download_mode;
  logic        dl_uart_en;
  logic        dl_i2c_en;
  logic        irq;
  logic [31:0] v;
  logic [15:0] a;
  logic [7:0]  b;
  int          g;
  int          n_errors;
  int          num_checks;

  host_model host (
    .ref_clk   (ref_clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  flash_protection_boot_control dut (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .factory_init    (factory_init),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .mem_rd          (mem_rd),
    .mem_addr        (mem_addr),
    .mem_dbg         (mem_dbg),
    .mem_fw          (mem_fw),
    .mem_rdata       (mem_rdata),
    .mem_rvalid      (mem_rvalid),
    .mem_denied      (mem_denied),
    .boot_select_pin (boot_pin),
    .download_mode   (download_mode),
    .dl_uart_en      (dl_uart_en),
    .dl_i2c_en       (dl_i2c_en),
    .irq             (irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp,
                      input string what);
    host.rd(ad, v);
    chk(what, exp, v);
  endtask

  function automatic logic exp_denied(input logic [15:0] ad,
                                      input logic dbg, fw,
                                      input logic [31:0] prot);
    if (ad >= FW_BASE) return !fw;
    return dbg && !prot[READ_LOCK_BIT];
  endfunction

  // Bit 8 of the expected byte marks a read whose data are not compared.
  task automatic mchk(input logic [15:0] ad, input logic dbg, fw,
                      input logic [31:0] prot, input logic [8:0] expd);
    logic dn;
    dn = exp_denied(ad, dbg, fw, prot);
    @(posedge ref_clk);
    mem_rd   <= 1'b1;
    mem_addr <= ad;
    mem_dbg  <= dbg;
    mem_fw   <= fw;
    @(posedge ref_clk);
    mem_rd   <= 1'b0;
    #1;
    chk_flag("mem_rvalid", 1'b1, mem_rvalid);
    chk_flag("mem_denied", dn, mem_denied);
    if (dn) chk("mem_rdata", 32'h0, {24'h0, mem_rdata});
    else if (!expd[8])
      chk("mem_rdata", {24'h0, expd[7:0]}, {24'h0, mem_rdata});
  endtask

  task automatic run_cmd(input logic [7:0] c, input logic [31:0] exp);
    host.wr(REG_COMMAND, {24'h0, c});
    rchk(REG_STATUS, exp, "status");
  endtask

  task automatic run_long(input logic [7:0] c);
    logic seen;
    int   k;
    seen = 1'b0;
    host.wr(REG_COMMAND, {24'h0, c});
    host.rd(REG_STATUS, v);
    chk("busy", 32'h4, v & 32'h4);
    for (k = 0; k < 40000 && v[2] === 1'b1; k++) begin
      host.rd(REG_STATUS, v);
      seen = seen | v[0];
    end
    if (k == 40000) begin
      n_errors++;
      results();
    end else begin
      chk_flag("erase pass", 1'b1, seen);
    end
  endtask

  task automatic prog(input logic [15:0] ad, input logic [7:0] by,
                      input logic [31:0] exp);
    host.wr(REG_ADDRESS, {16'h0, ad});
    host.wr(REG_DATA, {24'h0, by});
    run_cmd(CMD_WRITE, exp);
  endtask

  task automatic save_key(input logic [31:0] k, input logic [31:0] exp);
    host.wr(REG_ADDRESS, {16'h0, k[31:16]});
    host.wr(REG_DATA, {16'h0, k[15:0]});
    run_cmd(CMD_SAVE_PROT, exp);
  endtask

  task automatic do_reset(input logic pin);
    @(posedge ref_clk);
    boot_pin <= pin;
    rst      <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst          <= 1'b0;
    factory_init <= 1'b0;
  endtask

  task automatic boot_chk(input logic exp);
    #1;
    chk_flag("download_mode", exp, download_mode);
    chk_flag("dl_uart_en", exp, dl_uart_en);
    chk_flag("dl_i2c_en", exp, dl_i2c_en);
  endtask

  initial begin
    n_errors     = 0;
    num_checks   = 0;
    rst          = 1'b1;
    factory_init = 1'b1;
    boot_pin     = 1'b1;
    mem_rd       = 1'b0;
    mem_addr     = 16'h0000;
    mem_dbg      = 1'b0;
    mem_fw       = 1'b0;
    void'($urandom(39));
    do_reset(1'b1);
    rchk(REG_STATUS, 32'h0, "status");
    rchk(REG_MODE, 32'h0, "mode");
    rchk(REG_VOL_PROT, PROT_RESET, "vol prot");
    rchk(REG_PERS_PROT, PROT_RESET, "pers prot");
    rchk(REG_ACT_PROT, PROT_RESET, "act prot");
    rchk(REG_KEY_STATE, 32'h0, "key state");
    host.wr(8'h3C, 32'h12345678);
    rchk(8'h3C, 32'h0, "unmapped");
    boot_chk(1'b0);
    $display("test reset done");

    g = 1 + $urandom % 29;
    a = 16'(g * 2048) | 16'($urandom & 32'h7FF);
    b = 8'($urandom % 255);
    host.wr(REG_MODE, 32'h8);
    host.wr(REG_ADDRESS, {16'h0, a});
    run_long(CMD_PAGE_ERASE);
    prog(a, b, 32'h1);
    rchk(REG_STATUS, 32'h0, "status cleared");
    prog(a, 8'h00, 32'h2);
    host.wr(REG_ADDRESS, {16'h0, a});
    run_cmd(CMD_READ, 32'h1);
    host.rd(REG_DATA, v);
    chk("read byte", {24'h0, b}, v & 32'hFF);
    mchk(a, 1'b0, 1'b0, PROT_RESET, {1'b0, b});
    $display("test program done");

    host.wr(REG_VOL_PROT, ~(32'h1 << g));
    prog(a ^ 16'h1, 8'h00, 32'h2);
    mchk(a ^ 16'h1, 1'b0, 1'b0, PROT_RESET, 9'h0FF);
    host.wr(REG_MODE, 32'h0);
    run_cmd(CMD_PAGE_ERASE, 32'h2);
    host.wr(REG_MODE, 32'h8);
    host.wr(REG_VOL_PROT, 32'h7FFFFFFF);
    mchk(a, 1'b1, 1'b0, 32'h7FFFFFFF, {1'b0, b});
    mchk(a, 1'b0, 1'b0, 32'h7FFFFFFF, {1'b0, b});
    mchk(USER_LAST, 1'b0, 1'b0, 32'h7FFFFFFF, 9'h100);
    mchk(FW_BASE, 1'b0, 1'b0, 32'h7FFFFFFF, 9'h100);
    mchk(FW_LAST, 1'b0, 1'b1, 32'h7FFFFFFF, 9'h100);
    host.wr(REG_ADDRESS, {16'h0, FW_BASE});
    run_cmd(CMD_READ, 32'h2);
    run_cmd(8'h77, 32'h2);
    $display("test protection done");

    host.wr(REG_MODE, 32'h18);
    host.wr(REG_ADDRESS, {16'h0, a});
    run_cmd(CMD_READ, 32'h9);
    host.wr(REG_IRQ_STATUS, 32'h7);
    host.wr(REG_IRQ_MASK, 32'h4);
    repeat (2) @(posedge ref_clk);
    #1 chk_flag("irq", 1'b0, irq);
    mchk(a, 1'b1, 1'b0, 32'h7FFFFFFF, 9'h100);
    repeat (2) @(posedge ref_clk);
    #1 chk_flag("irq", 1'b1, irq);
    host.wr(REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1 chk_flag("irq masked", 1'b0, irq);
    host.wr(REG_IRQ_STATUS, 32'h4);
    host.wr(REG_IRQ_MASK, 32'h4);
    repeat (2) @(posedge ref_clk);
    #1 chk_flag("irq cleared", 1'b0, irq);
    rchk(REG_IRQ_STATUS, 32'h0, "irq status");
    $display("test interrupt done");

    host.wr(REG_PERS_PROT, 32'hFFFFFFFE);
    host.wr(REG_MODE, 32'h48);
    save_key(32'h12345678, 32'h1);
    rchk(REG_KEY_STATE, 32'h1, "key state");
    rchk(REG_ACT_PROT, PROT_RESET, "act prot");
    do_reset(1'b1);
    rchk(REG_ACT_PROT, 32'hFFFFFFFE, "act prot");
    rchk(REG_VOL_PROT, PROT_RESET, "vol prot");
    host.wr(REG_MODE, 32'h8);
    prog(16'h0010, 8'h00, 32'h2);
    host.wr(REG_MODE, 32'h48);
    host.wr(REG_PERS_PROT, 32'hFFFFFFFC);
    save_key(32'h11115678, 32'h2);
    save_key(32'h12345678, 32'h1);
    host.wr(REG_MODE, 32'h68);
    save_key(32'h12345678, 32'h2);
    rchk(REG_KEY_STATE, 32'h1, "key state");
    $display("test key done");

    host.wr(REG_MODE, 32'h8);
    run_long(CMD_MASS_ERASE);
    rchk(REG_KEY_STATE, 32'h0, "key state");
    mchk(a, 1'b0, 1'b0, PROT_RESET, 9'h0FF);
    do_reset(1'b1);
    rchk(REG_ACT_PROT, PROT_RESET, "act prot");
    host.wr(REG_MODE, 32'h48);
    save_key(KEY_PERMANENT, 32'h1);
    rchk(REG_KEY_STATE, 32'h3, "key state");
    save_key(KEY_PERMANENT, 32'h2);
    rchk(REG_KEY_STATE, 32'h3, "key state");
    $display("test erase and permanent done");

    do_reset(1'b0);
    boot_chk(1'b1);
    rchk(REG_BOOT, 32'h1, "boot reg");
    do_reset(1'b1);
    boot_chk(1'b0);
    $display("test boot done");
    results();
  end
endmodule

// *** verilog/flash_protection_boot_control.sv ***
// Protection, command control and boot selection of the program array.
//
// Contract
// - Top protection bit blocks debug-port reads of the whole user area.
// - Each other protection bit write-guards one 2 kB group of four pages.
// - Write protection holds for every access path into the array; mass erase ignores it and clears locked groups too.
// - Volatile protection is written directly and is lost at reset.
// - Persistent protection acts only after save command 0x0C and a reset.
// - Persistent protection is keyed; later changes must present the key.
// - Mass erase returns the key to 0xFFFF and erases all user code.
// - Key 0xDEADDEAD makes protection permanent; further key entry refused.
// - Lower 62 kB is user space, upper 2 kB holds boot firmware.
// - Firmware region is hidden from and inaccessible to user code.
// - Boot-select pin low at reset selects serial download mode.
// - Erase is per page; bytes program only into erased locations.
// - Download mode accepts code over the serial port or two-wire port.
// - Command fail flag sets on failure and clears when status is read.
`timescale 1ns/10ps
module flash_protection_boot_control
  import flash_protection_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              factory_init,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              mem_rd,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_dbg,
  input  wire logic              mem_fw,
  output logic      [7:0]        mem_rdata,
  output logic                   mem_rvalid,
  output logic                   mem_denied,
  input  wire logic              boot_select_pin,
  output logic                   download_mode,
  output logic                   dl_uart_en,
  output logic                   dl_i2c_en,
  output logic                   irq
);

  logic [7:0]        mem_q [ARRAY_BYTES];
  ctrl_state_e       state_q;
  logic [15:0]       mode_q;
  logic [7:0]        cmd_q;
  logic [15:0]       adr_q;
  logic [15:0]       dat_q;
  logic [31:0]       vol_q;
  logic [31:0]       pers_wr_q;
  logic [31:0]       pers_act_q;
  logic [31:0]       saved_q;
  logic [31:0]       key_q;
  logic              key_set_q;
  logic [15:0]       ptr_q;
  logic [15:0]       end_q;
  nvm_status_s       sts_q;
  irq_event_s        ev_q;
  irq_event_s        mask_q;
  logic              boot_s1_q;
  logic              boot_s2_q;
  logic [31:0]       eff_prot;
  logic [31:0]       key_in;
  logic              cmd_go;
  logic              cmd_pass;
  logic              cmd_fail;
  logic              prog_we;
  logic              erase_go;
  logic              mass_go;
  logic              save_go;
  logic              read_go;
  logic              erase_last;
  logic              sts_rd;
  logic              deny_now;
  irq_event_s        ev_set;

  function automatic logic in_fw(input logic [15:0] a);
    return a >= FW_BASE;
  endfunction

  function automatic logic write_locked(input logic [15:0] a,
                                        input logic [31:0] p);
    return in_fw(a) || !p[a[15:GROUP_LSB]];
  endfunction

  // A protection bit at zero locks its group; both registers must allow.
  assign eff_prot   = vol_q & pers_act_q;
  assign key_in     = {adr_q, dat_q};
  assign cmd_go     = reg_wr && reg_addr == REG_COMMAND && state_q == ST_IDLE;
  assign erase_last = state_q == ST_ERASE && ptr_q == end_q;
  assign sts_rd     = reg_rd && reg_addr == REG_STATUS;

  always_comb begin
    cmd_pass = 1'b0;
    cmd_fail = 1'b0;
    prog_we  = 1'b0;
    erase_go = 1'b0;
    mass_go  = 1'b0;
    save_go  = 1'b0;
    read_go  = 1'b0;
    if (cmd_go) begin
      case (reg_wdata[7:0])
        CMD_READ: begin
          read_go  = !in_fw(adr_q);
          cmd_pass = read_go;
          cmd_fail = !read_go;
        end
        CMD_WRITE: begin
          prog_we  = mode_q[MODE_EW_EN] && !write_locked(adr_q, eff_prot)
                     && mem_q[adr_q] == ERASED_BYTE;
          cmd_pass = prog_we;
          cmd_fail = !prog_we;
        end
        CMD_PAGE_ERASE: begin
          erase_go = mode_q[MODE_EW_EN]
                     && !write_locked(adr_q, eff_prot);
          cmd_fail = !erase_go;
        end
        CMD_MASS_ERASE: begin
          mass_go  = mode_q[MODE_EW_EN];
          cmd_fail = !mass_go;
        end
        CMD_SAVE_PROT: begin
          save_go  = mode_q[MODE_KEY_EN] && !mode_q[MODE_KEY_SEL]
                     && !(key_set_q && (key_q == KEY_PERMANENT
                                        || key_in != key_q));
          cmd_pass = save_go;
          cmd_fail = !save_go;
        end
        default: cmd_fail = 1'b1;
      endcase
    end
  end

  // Only firmware may see its own region; debug reads obey the read lock.
  always_comb begin
    deny_now = (in_fw(mem_addr) && !mem_fw)
               || (mem_dbg && !in_fw(mem_addr)
                   && !eff_prot[READ_LOCK_BIT]);
  end

  always_comb begin
    ev_set.done   = cmd_pass || erase_last;
    ev_set.fail   = cmd_fail;
    ev_set.denied = mem_rd && deny_now;
  end

  // Array storage; program and erase are the only writers.
  always_ff @(posedge ref_clk) begin
    if (prog_we) begin
      mem_q[adr_q] <= dat_q[7:0];
    end else if (state_q == ST_ERASE) begin
      mem_q[ptr_q] <= ERASED_BYTE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ptr_q   <= WORD16_RESET;
      end_q   <= WORD16_RESET;
    end else if (erase_go) begin
      state_q <= ST_ERASE;
      ptr_q   <= adr_q & ~PAGE_OFS_MASK;
      end_q   <= adr_q | PAGE_OFS_MASK;
    end else if (mass_go) begin
      state_q <= ST_ERASE;
      ptr_q   <= WORD16_RESET;
      end_q   <= USER_LAST;
    end else begin
      case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_ERASE: begin
          if (erase_last) begin
            state_q <= ST_IDLE;
          end else begin
            ptr_q <= ptr_q + 16'h0001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q    <= MODE_RESET;
      cmd_q     <= CMD_RESET;
      adr_q     <= WORD16_RESET;
      dat_q     <= WORD16_RESET;
      vol_q     <= PROT_RESET;
      pers_wr_q <= PROT_RESET;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          REG_MODE:      mode_q    <= reg_wdata[15:0];
          REG_ADDRESS:   adr_q     <= reg_wdata[15:0];
          REG_DATA:      dat_q     <= reg_wdata[15:0];
          REG_VOL_PROT:  vol_q     <= reg_wdata;
          REG_PERS_PROT: pers_wr_q <= reg_wdata;
          default:       mode_q    <= mode_q;
        endcase
      end
      if (cmd_go) begin
        cmd_q <= reg_wdata[7:0];
      end
      if (read_go) begin
        dat_q <= {8'h00, mem_q[adr_q]};
      end
    end
  end

  // Key and saved protection are nonvolatile: untouched by rst.
  always_ff @(posedge ref_clk) begin
    if (factory_init || mass_go) begin
      key_q     <= KEY_ERASED;
      key_set_q <= 1'b0;
      saved_q   <= PROT_RESET;
    end else if (save_go) begin
      key_q     <= key_in;
      key_set_q <= 1'b1;
      saved_q   <= pers_wr_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pers_act_q <= saved_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sts_q <= '0;
    end else begin
      sts_q.pass <= ev_set.done || (sts_q.pass && !sts_rd);
      sts_q.fail <= ev_set.fail || (sts_q.fail && !sts_rd);
      sts_q.irq  <= (ev_set.done && mode_q[MODE_IRQ_EN])
                    || (sts_q.irq && !sts_rd);
      sts_q.busy <= erase_go || mass_go
                    || (state_q == ST_ERASE && !erase_last);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ev_q   <= EVENT_RESET;
      mask_q <= EVENT_RESET;
      irq    <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == REG_IRQ_STATUS) begin
        ev_q <= ev_set | (ev_q & ~reg_wdata[2:0]);
      end else begin
        ev_q <= ev_set | ev_q;
      end
      if (reg_wr && reg_addr == REG_IRQ_MASK) begin
        mask_q <= reg_wdata[2:0];
      end
      irq <= |(ev_q & mask_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_rvalid <= 1'b0;
      mem_denied <= 1'b0;
      mem_rdata  <= 8'h00;
    end else begin
      mem_rvalid <= mem_rd;
      mem_denied <= mem_rd && deny_now;
      mem_rdata  <= (mem_rd && !deny_now) ? mem_q[mem_addr] : 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STATUS:     reg_rdata <= {28'h0000000, sts_q};
        REG_MODE:       reg_rdata <= {16'h0000, mode_q};
        REG_COMMAND:    reg_rdata <= {24'h000000, cmd_q};
        REG_ADDRESS:    reg_rdata <= {16'h0000, adr_q};
        REG_DATA:       reg_rdata <= {16'h0000, dat_q};
        REG_VOL_PROT:   reg_rdata <= vol_q;
        REG_PERS_PROT:  reg_rdata <= pers_wr_q;
        REG_ACT_PROT:   reg_rdata <= pers_act_q;
        REG_KEY_STATE:  reg_rdata <= {30'h00000000,
                                      key_q == KEY_PERMANENT, key_set_q};
        REG_IRQ_STATUS: reg_rdata <= {29'h00000000, ev_q};
        REG_IRQ_MASK:   reg_rdata <= {29'h00000000, mask_q};
        REG_BOOT:       reg_rdata <= {31'h00000000, download_mode};
        default:        reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk) begin
    boot_s1_q <= boot_select_pin;
    boot_s2_q <= boot_s1_q;
  end

  // The pin is sampled only while reset is held, so later changes are moot.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      download_mode <= !boot_s2_q;
      dl_uart_en    <= !boot_s2_q;
      dl_i2c_en     <= !boot_s2_q;
    end
  end

  sequence s_erase_busy;
    sts_q.busy [*8];
  endsequence

  property p_dbg_read_block;
    @(posedge ref_clk) disable iff (rst)
    mem_rd && mem_dbg && !in_fw(mem_addr) && !eff_prot[READ_LOCK_BIT]
      |=> mem_denied && mem_rdata == 8'h00;
  endproperty
  a_dbg_read_block: assert property (p_dbg_read_block)
    else $error("Debug read of locked user area not blocked.");

  property p_locked_write_fails;
    @(posedge ref_clk) disable iff (rst)
    cmd_go && reg_wdata[7:0] == CMD_WRITE && write_locked(adr_q, eff_prot)
      |-> !prog_we ##1 sts_q.fail;
  endproperty
  a_locked_write_fails: assert property (p_locked_write_fails)
    else $error("Write into locked group did not fail.");

  property p_no_locked_program;
    @(posedge ref_clk) disable iff (rst)
    prog_we |-> adr_q < FW_BASE && vol_q[adr_q[15:GROUP_LSB]]
                && pers_act_q[adr_q[15:GROUP_LSB]] && mode_q[MODE_EW_EN];
  endproperty
  a_no_locked_program: assert property (p_no_locked_program)
    else $error("Array programmed inside a locked group.");

  property p_vol_lost_at_reset;
    @(posedge ref_clk)
    rst |=> vol_q == PROT_RESET && mode_q == MODE_RESET;
  endproperty
  a_vol_lost_at_reset: assert property (p_vol_lost_at_reset)
    else $error("Volatile protection survived reset.");

  property p_active_only_at_reset;
    @(posedge ref_clk)
    !$stable(pers_act_q) |-> $past(rst);
  endproperty
  a_active_only_at_reset: assert property (p_active_only_at_reset)
    else $error("Persistent protection changed without reset.");

  property p_key_mismatch;
    @(posedge ref_clk) disable iff (rst || factory_init)
    cmd_go && reg_wdata[7:0] == CMD_SAVE_PROT && key_set_q && key_in != key_q
      |=> sts_q.fail && $stable(key_q) && $stable(saved_q);
  endproperty
  a_key_mismatch: assert property (p_key_mismatch)
    else $error("Save with wrong key was accepted.");

  property p_mass_erase_key;
    @(posedge ref_clk) disable iff (rst)
    mass_go |=> (key_q == KEY_ERASED && !key_set_q) and s_erase_busy;
  endproperty
  a_mass_erase_key: assert property (p_mass_erase_key)
    else $error("Mass erase did not clear the key.");

  property p_permanent_key;
    @(posedge ref_clk) disable iff (rst || factory_init)
    cmd_go && reg_wdata[7:0] == CMD_SAVE_PROT && key_set_q
      && key_q == KEY_PERMANENT |=> sts_q.fail && key_q == KEY_PERMANENT;
  endproperty
  a_permanent_key: assert property (p_permanent_key)
    else $error("Key entry accepted under permanent protection.");

  property p_fw_hidden;
    @(posedge ref_clk) disable iff (rst)
    mem_rd && in_fw(mem_addr) && !mem_fw
      |=> mem_denied && mem_rvalid && mem_rdata == 8'h00;
  endproperty
  a_fw_hidden: assert property (p_fw_hidden)
    else $error("Firmware region visible to user code.");

  property p_boot_select;
    @(posedge ref_clk)
    rst && !boot_s2_q |=> download_mode && dl_uart_en && dl_i2c_en;
  endproperty
  a_boot_select: assert property (p_boot_select)
    else $error("Low boot pin did not select download mode.");

  property p_page_erase_busy;
    @(posedge ref_clk) disable iff (rst)
    erase_go |=> s_erase_busy;
  endproperty
  a_page_erase_busy: assert property (p_page_erase_busy)
    else $error("Page erase finished too early.");

  property p_fail_clears_on_read;
    @(posedge ref_clk) disable iff (rst)
    sts_rd && !ev_set.fail |=> !sts_q.fail;
  endproperty
  a_fail_clears_on_read: assert property (p_fail_clears_on_read)
    else $error("Command fail flag not cleared by status read.");

endmodule

// *** verilog/flash_protection_pkg.sv ***
// Constants, field layouts and carrier types of the flash protection block.
package flash_protection_pkg;

  localparam int          ADDR_W        = 16;
  localparam int          ARRAY_BYTES   = 65536;
  localparam logic [15:0] FW_BASE       = 16'hF800;
  localparam logic [15:0] FW_LAST       = 16'hFFFF;
  localparam logic [15:0] USER_LAST     = 16'hF7FF;
  localparam logic [15:0] PAGE_OFS_MASK = 16'h01FF;
  localparam int          GROUP_LSB     = 11;
  localparam int          READ_LOCK_BIT = 31;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

  localparam logic [7:0]  REG_STATUS     = 8'h00;
  localparam logic [7:0]  REG_MODE       = 8'h04;
  localparam logic [7:0]  REG_COMMAND    = 8'h08;
  localparam logic [7:0]  REG_ADDRESS    = 8'h0C;
  localparam logic [7:0]  REG_DATA       = 8'h10;
  localparam logic [7:0]  REG_VOL_PROT   = 8'h20;
  localparam logic [7:0]  REG_PERS_PROT  = 8'h24;
  localparam logic [7:0]  REG_ACT_PROT   = 8'h28;
  localparam logic [7:0]  REG_KEY_STATE  = 8'h2C;
  localparam logic [7:0]  REG_IRQ_STATUS = 8'h30;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h34;
  localparam logic [7:0]  REG_BOOT       = 8'h38;

  localparam logic [7:0]  CMD_READ       = 8'h01;
  localparam logic [7:0]  CMD_WRITE      = 8'h02;
  localparam logic [7:0]  CMD_PAGE_ERASE = 8'h05;
  localparam logic [7:0]  CMD_MASS_ERASE = 8'h06;
  localparam logic [7:0]  CMD_SAVE_PROT  = 8'h0C;

  localparam int MODE_EW_EN   = 3;
  localparam int MODE_IRQ_EN  = 4;
  localparam int MODE_KEY_SEL = 5;
  localparam int MODE_KEY_EN  = 6;

  localparam logic [31:0] PROT_RESET    = 32'hFFFFFFFF;
  localparam logic [31:0] KEY_ERASED    = 32'h0000FFFF;
  localparam logic [31:0] KEY_PERMANENT = 32'hDEADDEAD;
  localparam logic [15:0] MODE_RESET    = 16'h0000;
  localparam logic [15:0] WORD16_RESET  = 16'h0000;
  localparam logic [7:0]  CMD_RESET     = 8'h00;
  localparam logic [2:0]  EVENT_RESET   = 3'h0;

  typedef struct packed {
    logic irq;
    logic busy;
    logic fail;
    logic pass;
  } nvm_status_s;

  typedef struct packed {
    logic denied;
    logic fail;
    logic done;
  } irq_event_s;

  typedef enum logic {ST_IDLE, ST_ERASE} ctrl_state_e;

endpackage
